/* verilog/ump_ctrl.sv */
// ump_ctrl: one channel of modem pin control, low power and receive-ready logic
// assumes the host writes modem control through modem_control_wr_i/modem_control_wdata_i on clk_i
//
// Functional notes
// - low-power input high enters sleep after passing the input synchroniser, gates clock and isolates host pins
// - sleep lasts until input released; its falling edge resets the modem control register and the ring interrupt flag
// - control bit 3 set drives interrupt output actively and user output low
// - control bit 3 clear floats interrupt output and drives user output high
// - master reset loads the reset values into registers and outputs, so osc_enable_o is high; transmit and receive disabled meanwhile
// - ring input rising to one raises a channel interrupt
// - control bit 1 set drives the send request output low
// - after any reset the send request output is high
// - loopback ignores external serial input and feeds transmit data to receiver
// - receive-ready goes low in single mode when one or more characters are held
// - receive-ready high when empty or trigger not reached in block mode
// - receive-ready serves as per-character request in single-transfer mode
// - control bit 0 set drives terminal-ready low; clear or reset returns high
// - clear-to-send input state readable in status bit 4
`timescale 1ns/10ps
`default_nettype none
`include "ump_map.svh"
module ump_ctrl
    import ump_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic low_power_request_in_i,
    input wire logic modem_control_wr_i,
    input wire logic [7:0] modem_control_wdata_i,
    input wire logic modem_status_rd_i,
    input wire logic ring_detect_n_i,
    input wire logic clear_to_send_n_i,
    input wire logic serial_in_i,
    input wire logic tx_data_i,
    input wire logic irq_pending_i,
    input wire ump_rxstat_t rxstat_i,
    output logic irq_out_o,
    output logic irq_out_oe_o,
    output logic user_output_n_o,
    output logic send_request_n_o,
    output logic terminal_ready_n_o,
    output logic rx_serial_o,
    output logic rx_avail_n_o,
    output logic host_isolate_o,
    output logic osc_enable_o,
    output logic [7:0] modem_status_reg_o
);
    ////////////////////////////////////////////////////////////////////////////////
    // synchronised pins
    logic lp_s;
    logic ri_s;
    logic cts_s;
    logic rx_s;
    ump_sync #(.RST_VAL(1'b0)) u_lp (.clk_i(clk_i), .nrst_i(nrst_i), .d_i(low_power_request_in_i), .q_o(lp_s));
    ump_sync #(.RST_VAL(1'b1)) u_ri (.clk_i(clk_i), .nrst_i(nrst_i), .d_i(ring_detect_n_i), .q_o(ri_s));
    ump_sync #(.RST_VAL(1'b1)) u_cts (.clk_i(clk_i), .nrst_i(nrst_i), .d_i(clear_to_send_n_i), .q_o(cts_s));
    ump_sync #(.RST_VAL(1'b1)) u_rx (.clk_i(clk_i), .nrst_i(nrst_i), .d_i(serial_in_i), .q_o(rx_s));

    function automatic logic rx_ready(input ump_rxstat_t s);
        // block mode waits for the trigger, single mode any held character
        if (s.level == 8'h00)
            rx_ready = 1'b0;
        else if (s.dma_mode)
            rx_ready = (s.level >= s.trigger);
        else
            rx_ready = 1'b1;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // power state and register file
    ump_pwr_t pwr_reg;
    ump_pwr_t pwr_next;
    logic [7:0] modem_control_reg;
    logic [7:0] modem_control_next;
    logic teri_reg;
    logic teri_next;
    logic ri_d_reg;
    logic ri_d_next;
    logic soft_rst;

    always_comb begin
        pwr_next = pwr_reg;
        case (pwr_reg)
            UMP_RUN: if (lp_s) pwr_next = UMP_SLEEP;
            UMP_SLEEP: if (!lp_s) pwr_next = UMP_WAKE;
            UMP_WAKE: pwr_next = UMP_RUN;
            default: pwr_next = UMP_RUN;
        endcase
    end
    assign soft_rst = (pwr_reg == UMP_WAKE);

    always_comb begin
        modem_control_next = modem_control_reg;
        teri_next = teri_reg;
        ri_d_next = ri_s;
        if (soft_rst) begin
            modem_control_next = `UMP_CTL_RESET;
            teri_next = 1'b0;
        end else begin
            if (modem_control_wr_i && pwr_reg == UMP_RUN)
                modem_control_next = modem_control_wdata_i;
            if (modem_status_rd_i)
                teri_next = 1'b0;
            if (ri_s && !ri_d_reg)
                teri_next = 1'b1; // set wins over read clear
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pwr_reg <= UMP_RUN;
            modem_control_reg <= `UMP_CTL_RESET;
            teri_reg <= 1'b0;
            ri_d_reg <= 1'b1;
        end else begin
            pwr_reg <= pwr_next;
            modem_control_reg <= modem_control_next;
            teri_reg <= teri_next;
            ri_d_reg <= ri_d_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // registered pin outputs
    logic irq_next;
    logic irq_oe_next;
    logic op_n_next;
    logic rts_n_next;
    logic dtr_n_next;
    logic rxs_next;
    logic rxa_n_next;
    logic iso_next;
    logic osc_next;
    logic [7:0] modem_status_next;
    logic irq_reg;
    logic irq_oe_reg;
    logic op_n_reg;
    logic rts_n_reg;
    logic dtr_n_reg;
    logic rxs_reg;
    logic rxa_n_reg;
    logic iso_reg;
    logic osc_reg;
    logic [7:0] modem_status_reg;

    always_comb begin
        irq_oe_next = modem_control_next[`UMP_CTL_OP2_BIT];
        op_n_next = ~modem_control_next[`UMP_CTL_OP2_BIT];
        irq_next = irq_pending_i | teri_next;
        rts_n_next = ~modem_control_next[`UMP_CTL_RTS_BIT];
        dtr_n_next = ~modem_control_next[`UMP_CTL_DTR_BIT];
        rxs_next = modem_control_next[`UMP_CTL_LOOP_BIT] ? tx_data_i : rx_s;
        rxa_n_next = ~rx_ready(rxstat_i);
        iso_next = (pwr_next == UMP_SLEEP);
        osc_next = (pwr_next != UMP_SLEEP);
        modem_status_next = `UMP_STAT_RESET;
        modem_status_next[`UMP_STAT_CTS_BIT] = ~cts_s;
        modem_status_next[`UMP_STAT_RI_BIT] = ~ri_s;
        modem_status_next[`UMP_STAT_TERI_BIT] = teri_next;
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_reg <= 1'b0;
            irq_oe_reg <= 1'b0;
            op_n_reg <= 1'b1;
            rts_n_reg <= 1'b1;
            dtr_n_reg <= 1'b1;
            rxs_reg <= 1'b1;
            rxa_n_reg <= 1'b1;
            iso_reg <= 1'b0;
            osc_reg <= 1'b1;
            modem_status_reg <= `UMP_STAT_RESET;
        end else begin
            irq_reg <= irq_next;
            irq_oe_reg <= irq_oe_next;
            op_n_reg <= op_n_next;
            rts_n_reg <= rts_n_next;
            dtr_n_reg <= dtr_n_next;
            rxs_reg <= rxs_next;
            rxa_n_reg <= rxa_n_next;
            iso_reg <= iso_next;
            osc_reg <= osc_next;
            modem_status_reg <= modem_status_next;
        end
    end

    assign irq_out_o = irq_reg;
    assign irq_out_oe_o = irq_oe_reg;
    assign user_output_n_o = op_n_reg;
    assign send_request_n_o = rts_n_reg;
    assign terminal_ready_n_o = dtr_n_reg;
    assign rx_serial_o = rxs_reg;
    assign rx_avail_n_o = rxa_n_reg;
    assign host_isolate_o = iso_reg;
    assign osc_enable_o = osc_reg;
    assign modem_status_reg_o = modem_status_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // assertions
    property p_op2_pair;
        @(posedge clk_i) disable iff (!nrst_i) irq_out_oe_o == ~user_output_n_o;
    endproperty
    a_op2_pair: assert property (p_op2_pair) else $error("irq enable and user output disagree");

    property p_op2_set;
        @(posedge clk_i) disable iff (!nrst_i)
            $rose(modem_control_reg[`UMP_CTL_OP2_BIT]) |-> irq_out_oe_o && !user_output_n_o;
    endproperty
    a_op2_set: assert property (p_op2_set) else $error("bit 3 set did not enable irq");

    property p_rts;
        @(posedge clk_i) disable iff (!nrst_i) send_request_n_o == ~modem_control_reg[`UMP_CTL_RTS_BIT];
    endproperty
    a_rts: assert property (p_rts) else $error("send request does not follow bit 1");

    property p_dtr;
        @(posedge clk_i) disable iff (!nrst_i) terminal_ready_n_o == ~modem_control_reg[`UMP_CTL_DTR_BIT];
    endproperty
    a_dtr: assert property (p_dtr) else $error("terminal ready does not follow bit 0");

    property p_wake_reset;
        @(posedge clk_i) disable iff (!nrst_i)
            pwr_reg == UMP_WAKE |=> modem_control_reg == `UMP_CTL_RESET && send_request_n_o;
    endproperty
    a_wake_reset: assert property (p_wake_reset) else $error("wake did not reset registers");

    property p_sleep;
        @(posedge clk_i) disable iff (!nrst_i) $rose(lp_s) |=> ##1 host_isolate_o && !osc_enable_o;
    endproperty
    a_sleep: assert property (p_sleep) else $error("low power not entered");

    property p_ring;
        @(posedge clk_i) disable iff (!nrst_i) $rose(ri_s) |=> irq_out_o && modem_status_reg_o[`UMP_STAT_TERI_BIT];
    endproperty
    a_ring: assert property (p_ring) else $error("ring edge raised no interrupt");

    property p_cts;
        @(posedge clk_i) disable iff (!nrst_i) ##1 modem_status_reg_o[`UMP_STAT_CTS_BIT] == !$past(cts_s);
    endproperty
    a_cts: assert property (p_cts) else $error("status bit 4 wrong");

    property p_empty;
        @(posedge clk_i) disable iff (!nrst_i) rxstat_i.level == 8'h00 |=> rx_avail_n_o;
    endproperty
    a_empty: assert property (p_empty) else $error("receive ready low while empty");

    property p_single;
        @(posedge clk_i) disable iff (!nrst_i) !rxstat_i.dma_mode && rxstat_i.level != 8'h00 |=> !rx_avail_n_o;
    endproperty
    a_single: assert property (p_single) else $error("single mode request missing");

    property p_loop;
        @(posedge clk_i) disable iff (!nrst_i)
            modem_control_next[`UMP_CTL_LOOP_BIT] |=> rx_serial_o == $past(tx_data_i);
    endproperty
    a_loop: assert property (p_loop) else $error("loopback not routed");

    c_sleep: cover property (@(posedge clk_i) disable iff (!nrst_i) pwr_reg == UMP_SLEEP ##[1:20] pwr_reg == UMP_WAKE);
    c_ring: cover property (@(posedge clk_i) disable iff (!nrst_i) $rose(ri_s));
    c_block: cover property (@(posedge clk_i) disable iff (!nrst_i) rxstat_i.dma_mode && $fell(rx_avail_n_o));
endmodule // ump_ctrl
`default_nettype wire

/* verilog/ump_map.svh */
// ump_map.svh: bit positions, reset values and widths for the modem pin control block
// assumes inclusion by bare name from the design files
`ifndef UMP_MAP_SVH
`define UMP_MAP_SVH
`define UMP_CTL_DTR_BIT 0
`define UMP_CTL_RTS_BIT 1
`define UMP_CTL_OP2_BIT 3
`define UMP_CTL_LOOP_BIT 4
`define UMP_STAT_CTS_BIT 4
`define UMP_STAT_RI_BIT 6
`define UMP_STAT_TERI_BIT 2
`define UMP_CTL_RESET 8'h00
`define UMP_STAT_RESET 8'h00
`define UMP_LVL_W 8
`endif

/* verilog/ump_pkg.sv */
// ump_pkg: types for the modem pin control block
// assumes ump_map.svh is on the include path
package ump_pkg;
    typedef enum logic [1:0] {
        UMP_RUN = 2'b00,
        UMP_SLEEP = 2'b01,
        UMP_WAKE = 2'b10
    } ump_pwr_t;
    typedef struct packed {
        logic [7:0] level;
        logic [7:0] trigger;
        logic dma_mode;
    } ump_rxstat_t;
endpackage

/* verilog/ump_sync.sv */
// ump_sync: three-stage input synchroniser with agreement filter
// assumes one clock domain, asynchronous active-low reset
`timescale 1ns/10ps
`default_nettype none
module ump_sync #(
    parameter logic RST_VAL = 1'b1
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic d_i,
    output logic q_o
);
    logic [2:0] sh_reg;
    logic [2:0] sh_next;
    logic q_reg;
    logic q_next;
    always_comb begin
        sh_next = {sh_reg[1:0], d_i};
        q_next = (sh_reg[1] == sh_reg[2]) ? sh_reg[2] : q_reg;
    end
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sh_reg <= {3{RST_VAL}};
            q_reg <= RST_VAL;
        end else begin
            sh_reg <= sh_next;
            q_reg <= q_next;
        end
    end
    assign q_o = q_reg;
endmodule // ump_sync
`default_nettype wire

/* testbench/ump_modem.sv */
// ump_modem: behavioural far-side modem for one channel of the pin control block
// assumes commands from the bench change at the falling edge of clk_i
`timescale 1ns/10ps
`default_nettype none
module ump_modem (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic ring_i,
    input wire logic cts_i,
    input wire logic tx_on_i,
    input wire logic tx_bit_i,
    output logic ring_detect_n_o,
    output logic clear_to_send_n_o,
    output logic serial_o
);
    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ring_detect_n_o <= 1'b1;
            clear_to_send_n_o <= 1'b1;
            serial_o <= 1'b1;
        end else begin
            ring_detect_n_o <= ~ring_i;
            clear_to_send_n_o <= ~cts_i;
            serial_o <= tx_on_i ? tx_bit_i : 1'b1;
        end
    end
endmodule // ump_modem
`default_nettype wire

/* testbench/tb.sv */
// tb: self-checking bench for ump_ctrl with a modem model on the line side
// assumes a 20 MHz clock and inputs driven at the falling edge
`timescale 1ns/10ps
`default_nettype none
module tb;
    import ump_pkg::*;
    logic clk_i = 1'b0, nrst_i = 1'b0, lp = 1'b0, wr = 1'b0, rd = 1'b0, txd = 1'b1, pend = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic ring = 1'b0, cts = 1'b0, ton = 1'b0, tbit = 1'b1, ri_n, cts_n, sin;
    ump_rxstat_t rxs = '0;
    logic irq, oe, user_n, rts_n, dtr_n, rxo, avail_n, iso, osc;
    logic [7:0] status;
    int n_errors = 0, num_checks = 0, cycles = 0;
    always #25 clk_i = ~clk_i;
    ump_modem u_ump_modem (.clk_i(clk_i), .nrst_i(nrst_i), .ring_i(ring), .cts_i(cts), .tx_on_i(ton),
        .tx_bit_i(tbit), .ring_detect_n_o(ri_n), .clear_to_send_n_o(cts_n), .serial_o(sin));
    ump_ctrl u_ump_ctrl (.clk_i(clk_i), .nrst_i(nrst_i), .low_power_request_in_i(lp), .modem_control_wr_i(wr),
        .modem_control_wdata_i(wdata), .modem_status_rd_i(rd), .ring_detect_n_i(ri_n), .clear_to_send_n_i(cts_n),
        .serial_in_i(sin), .tx_data_i(txd), .irq_pending_i(pend), .rxstat_i(rxs), .irq_out_o(irq),
        .irq_out_oe_o(oe), .user_output_n_o(user_n), .send_request_n_o(rts_n), .terminal_ready_n_o(dtr_n),
        .rx_serial_o(rxo), .rx_avail_n_o(avail_n), .host_isolate_o(iso), .osc_enable_o(osc),
        .modem_status_reg_o(status));
    ////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic seen, input logic exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    task automatic ctl_write(input logic [7:0] d);
        wr = 1'b1;
        wdata = d;
        cyc(1);
        wr = 1'b0;
        cyc(3);
    endtask
    task automatic reset_values();
        chk(rts_n, 1'b1);
        chk(dtr_n, 1'b1);
        chk(oe, 1'b0);
        chk(user_n, 1'b1);
        chk(iso, 1'b0);
        chk(osc, 1'b1);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_control();
        ctl_write(8'h0b);
        chk(rts_n, 1'b0);
        chk(dtr_n, 1'b0);
        chk(oe, 1'b1);
        chk(user_n, 1'b0);
        pend = 1'b1;
        cyc(3);
        chk(irq, 1'b1);
        pend = 1'b0;
        ctl_write(8'h00);
        reset_values();
        $display("control done");
    endtask
    task automatic t_ring();
        ctl_write(8'h08); // interrupt pin only, user output unused
        ring = 1'b1;
        cts = 1'b1;
        cyc(8);
        chk(status[6], 1'b1);
        chk(status[4], 1'b1);
        chk(irq, 1'b0);
        ring = 1'b0;
        cts = 1'b0;
        cyc(8);
        chk(status[2], 1'b1);
        chk(irq, 1'b1);
        chk(status[4], 1'b0);
        rd = 1'b1;
        cyc(1);
        rd = 1'b0;
        cyc(3);
        chk(status[2], 1'b0);
        chk(irq, 1'b0);
        $display("ring done");
    endtask
    task automatic t_loop();
        ctl_write(8'h10);
        txd = 1'b0;
        cyc(3);
        chk(rxo, 1'b0);
        txd = 1'b1;
        ton = 1'b1;
        tbit = 1'b0;
        cyc(8);
        chk(rxo, 1'b1);
        ctl_write(8'h00);
        cyc(4);
        chk(rxo, 1'b0);
        ton = 1'b0;
        cyc(8);
        chk(rxo, 1'b1);
        $display("loopback done");
    endtask
    task automatic t_ready();
        rxs = '{level: 8'h01, trigger: 8'h00, dma_mode: 1'b0};
        cyc(3);
        chk(avail_n, 1'b0);
        rxs.level = 8'h00;
        cyc(3);
        chk(avail_n, 1'b1);
        rxs = '{level: 8'h03, trigger: 8'h04, dma_mode: 1'b1};
        cyc(3);
        chk(avail_n, 1'b1);
        rxs.level = 8'h04;
        cyc(3);
        chk(avail_n, 1'b0);
        rxs = '{level: 8'h00, trigger: 8'h00, dma_mode: 1'b1};
        cyc(3);
        chk(avail_n, 1'b1);
        $display("ready done");
    endtask
    task automatic t_power();
        ctl_write(8'h0b);
        lp = 1'b1;
        cyc(8);
        chk(iso, 1'b1);
        chk(osc, 1'b0);
        ctl_write(8'h00);
        chk(rts_n, 1'b0);
        lp = 1'b0;
        cyc(8);
        reset_values();
        ctl_write(8'h02);
        chk(rts_n, 1'b0);
        nrst_i = 1'b0;
        cyc(2);
        reset_values();
        nrst_i = 1'b1;
        cyc(2);
        reset_values();
        $display("power done");
    endtask
    ////////////////////////////////////////////////////////////////////////////
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            conclude();
        end
    end
    initial begin
        cyc(12);
        reset_values();
        nrst_i = 1'b1;
        cyc(2);
        t_control();
        t_ring();
        t_loop();
        t_ready();
        t_power();
        conclude();
    end
endmodule // tb
`default_nettype wire
